// ===== core/psfi_pkg.sv
// Purpose: Shared constants for the port status and fault indicator.
// Assumes: 100 MHz hclk, word-wide AHB-Lite register access.
// Notes: Input vector layout is shared by the synchroniser and the core.
package psfi_pkg;

   // ==========================================
   // Clock and timing
   // ==========================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 17;
   localparam int HALF_W = 16;
   localparam logic [HALF_W-1:0] FLASH_HALF_MS_RST = 16'h007d;

   // ==========================================
   // Ports and synchronised input layout
   // ==========================================
   localparam int NPORT = 8;
   localparam int SYNC_W = 29;
   localparam int SY_LINK = 0;
   localparam int SY_RX = 8;
   localparam int SY_MASK = 16;
   localparam int SY_GOOD1 = 24;
   localparam int SY_GOOD2 = 25;
   localparam int SY_LOW1 = 26;
   localparam int SY_LOW2 = 27;
   localparam int SY_RAIL = 28;

   // ==========================================
   // Register map
   // ==========================================
   localparam int IDX_W = 6;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_FLASH = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_STICKY = 8'h0c;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int STK_SUPPLY = 0;
   localparam int STK_PERM = 1;
   localparam int STK_LINK = 2;
   localparam int STK_W = 3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Returns true when a word index selects the register at a byte offset.
   function automatic logic psfi_hit(input logic [IDX_W-1:0] idx, input logic [7:0] off);
      psfi_hit = (idx == off[7:2]);
   endfunction

endpackage

// ===== core/psfi_reg_if.sv
// Purpose: Register access carrier between the bus slave and the core.
// Assumes: One write strobe per transfer, read data combinational from the core.
// Notes: Index is the word address, byte offset divided by four.
`timescale 1ns/1ns
interface psfi_reg_if;
   logic [psfi_pkg::IDX_W-1:0] idx;
   logic wr_stb;
   logic [31:0] wdata;
   logic [31:0] rdata;

   // Bus side drives the access, core answers with read data.
   modport bus (output idx, output wr_stb, output wdata, input rdata);
   modport core (input idx, input wr_stb, input wdata, output rdata);
endinterface

// ===== core/psfi_sync.sv
// Purpose: Two-flop synchroniser for all monitor, link and switch inputs.
// Assumes: Inputs are slow levels.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ns
module psfi_sync (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Raw and synchronised levels
   input wire logic [psfi_pkg::SYNC_W-1:0] raw,
   output logic [psfi_pkg::SYNC_W-1:0] stable
);

   typedef struct packed {
      logic [psfi_pkg::SYNC_W-1:0] meta;
      logic [psfi_pkg::SYNC_W-1:0] stable;
   } psfi_sync_t;

   psfi_sync_t s_q;
   psfi_sync_t s_d;

   // Shift the raw levels through two stages.
   always_comb begin
      s_d = s_q;
      s_d.meta = raw;
      s_d.stable = s_q.meta;
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign stable = s_q.stable;
endmodule

// ===== core/psfi_ahb_slave.sv
// Purpose: AHB-Lite slave reaching the indicator registers.
// Assumes: Single word transfers only; the response is always OKAY.
// Notes: Every transfer takes one wait state; writes land on the edge that ends the data phase.
`timescale 1ns/1ns
module psfi_ahb_slave (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register carrier
   psfi_reg_if.bus regs
);

   typedef struct packed {
      logic pend;
      logic wr;
      logic [psfi_pkg::IDX_W-1:0] idx;
      logic ready;
      logic resp;
      logic [31:0] rdata;
      logic wr_stb;
      logic [31:0] wdata;
   } psfi_ahb_t;

   psfi_ahb_t s_q;
   psfi_ahb_t s_d;
   logic take;

   // An address phase is accepted when selected, NONSEQ or SEQ, and the bus is ready.
   assign take = hsel && hready && htrans[1];

   // Address capture, one wait state, then write strobe or read data.
   always_comb begin
      s_d = s_q;
      s_d.wr_stb = 1'b0;
      s_d.resp = 1'b0;
      if (s_q.pend) begin
         s_d.pend = 1'b0;
         s_d.ready = 1'b1;
         if (s_q.wr) begin
            s_d.wr_stb = 1'b1;
            s_d.wdata = hwdata;
         end else begin
            s_d.rdata = regs.rdata;
         end
      end else if (take) begin
         s_d.pend = 1'b1;
         s_d.ready = 1'b0;
         s_d.wr = hwrite;
         s_d.idx = haddr[psfi_pkg::IDX_W+1:2];
      end
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.ready;
   assign hresp = s_q.resp;
   assign hrdata = s_q.rdata;
   assign regs.idx = s_q.idx;
   assign regs.wr_stb = s_q.wr_stb;
   assign regs.wdata = s_q.wdata;
endmodule

// ===== core/psfi_top.sv
// Purpose: Fault relay, supply, fault and port LED drive for an eight-port switch.
// Assumes: Monitor flags arrive as digital levels; hsize is always a word.
// Notes: Relay output high means coil energised, contact closed, no fault.
//
// How it works
// RULE_01: Relay is energised when healthy and opens on any fault.
// RULE_02: Either supply-good flag low raises the relay fault.
// RULE_03: Rail monitor failure or either supply below 9.6 V is a fault.
// RULE_04: Missing link raises the fault only on ports whose mask switch enables it.
// RULE_05: Link supervision starts disabled on every port after reset.
// RULE_06: A single fed supply still reports the unfed one as failed.
// RULE_07: Supply LED lit while supply present, dark when below 9.6 V.
// RULE_08: Fault LED lit while any error exists, else dark.
// RULE_09: Port LED dark without valid link or when masked.
// RULE_10: Unmasked port LED steady green on link with no receive activity.
// RULE_11: Unmasked port LED flashes yellow while receive activity is present.
// RULE_12: Mask switch at 0 suppresses that port's LED indication.
// RULE_13: Yellow flash comes from a prescaled toggle; yellow wins over green.
// RULE_14: Fault LED follows the relay fault; all inputs are synchronised.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module psfi_top #(
   parameter int TICK_CYCLES = psfi_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Supply and internal monitors
   input wire logic supply_one_good,
   input wire logic supply_two_good,
   input wire logic supply_one_low,
   input wire logic supply_two_low,
   input wire logic rail_3v3_fail,
   // Port link and receive activity
   input wire logic [7:0] port_link,
   input wire logic [7:0] port_rx_active,
   // Front-panel link-report mask switches
   input wire logic link_mask_port_one,
   input wire logic link_mask_port_two,
   input wire logic link_mask_port_three,
   input wire logic link_mask_port_four,
   input wire logic link_mask_port_five,
   input wire logic link_mask_port_six,
   input wire logic link_mask_port_seven,
   input wire logic link_mask_port_eight,
   // Relay and indicators
   output logic fault_relay_energise,
   output logic supply_one_led,
   output logic supply_two_led,
   output logic fault_led,
   output logic [7:0] port_activity_led_green,
   output logic [7:0] port_activity_led_yellow
);

   // ==========================================
   // Types and state
   // ==========================================
   typedef struct packed {
      logic [psfi_pkg::TICK_W-1:0] pre_cnt;
      logic [psfi_pkg::HALF_W-1:0] ms_cnt;
      logic flash;
      logic [7:0] sup_en;
      logic [psfi_pkg::HALF_W-1:0] flash_half;
      logic [psfi_pkg::STK_W-1:0] sticky;
      logic relay;
      logic led_s1;
      logic led_s2;
      logic led_fault;
      logic [7:0] led_green;
      logic [7:0] led_yellow;
   } psfi_core_t;

   psfi_core_t s_q;
   psfi_core_t s_d;

   localparam logic [psfi_pkg::TICK_W-1:0] TICK_LAST = psfi_pkg::TICK_W'(TICK_CYCLES - 1);
   localparam logic [psfi_pkg::HALF_W-1:0] HALF_ONE = 16'h0001;

   // ==========================================
   // Bus slave and synchroniser
   // ==========================================
   psfi_reg_if regs ();

   // Word-wide register access with one wait state per transfer.
   psfi_ahb_slave u_ahb (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .regs(regs)
   );

   logic [psfi_pkg::SYNC_W-1:0] raw_in;
   logic [psfi_pkg::SYNC_W-1:0] sy;

   // Gather every asynchronous level into one vector for the synchroniser.
   assign raw_in = {rail_3v3_fail, supply_two_low, supply_one_low, supply_two_good, supply_one_good,
                    link_mask_port_eight, link_mask_port_seven, link_mask_port_six, link_mask_port_five,
                    link_mask_port_four, link_mask_port_three, link_mask_port_two, link_mask_port_one,
                    port_rx_active, port_link};

   // All monitor and switch inputs pass two flops before use. [RULE_14]
   psfi_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(raw_in),
      .stable(sy)
   );

   // ==========================================
   // Fault decision
   // ==========================================
   logic [7:0] link_ok;
   logic [7:0] rx_act;
   logic [7:0] mask_on;
   logic good1;
   logic good2;
   logic low1;
   logic low2;
   logic rail_bad;

   // Named views of the synchronised vector.
   assign link_ok = sy[psfi_pkg::SY_LINK +: psfi_pkg::NPORT];
   assign rx_act = sy[psfi_pkg::SY_RX +: psfi_pkg::NPORT];
   assign mask_on = sy[psfi_pkg::SY_MASK +: psfi_pkg::NPORT];
   assign good1 = sy[psfi_pkg::SY_GOOD1];
   assign good2 = sy[psfi_pkg::SY_GOOD2];
   assign low1 = sy[psfi_pkg::SY_LOW1];
   assign low2 = sy[psfi_pkg::SY_LOW2];
   assign rail_bad = sy[psfi_pkg::SY_RAIL];

   logic supply_fail;
   logic perm_fault;
   logic [7:0] link_watch;
   logic link_fault;
   logic any_fault;

   // Both supplies must be present, so a single fed input is a failure. [RULE_02] [RULE_06]
   assign supply_fail = !good1 || !good2;
   // Rail monitor or undervoltage on either supply is a permanent fault. [RULE_03]
   assign perm_fault = rail_bad || low1 || low2;
   // A port is watched only if its switch reports and software enabled it. [RULE_04] [RULE_12]
   assign link_watch = mask_on & s_q.sup_en;
   assign link_fault = |(link_watch & ~link_ok); // [RULE_04]
   assign any_fault = supply_fail || perm_fault || link_fault;

   // ==========================================
   // Port LED shaping
   // ==========================================
   logic [7:0] show;
   logic [7:0] green_d;
   logic [7:0] yellow_d;

   // Each port is shown only with a link and an enabling switch.
   for (genvar p = 0; p < psfi_pkg::NPORT; p++) begin : g_port
      assign show[p] = link_ok[p] && mask_on[p]; // [RULE_09] [RULE_12]
      assign green_d[p] = show[p] && !rx_act[p]; // [RULE_10] [RULE_13]
      assign yellow_d[p] = show[p] && rx_act[p] && s_q.flash; // [RULE_11] [RULE_13]
   end

   // ==========================================
   // Register read mux
   // ==========================================
   logic [31:0] status_word;

   // Live view of the synchronised inputs and the fault decision.
   assign status_word = {mask_on, rx_act, link_ok, 1'b0, s_q.flash, any_fault,
                         rail_bad, low2, low1, good2, good1};

   // Read data for the addressed word; unmapped words read zero.
   always_comb begin
      regs.rdata = psfi_pkg::RDATA_ZERO;
      if (psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_CTRL)) begin
         regs.rdata = {24'h00_0000, s_q.sup_en};
      end else if (psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_FLASH)) begin
         regs.rdata = {16'h0000, s_q.flash_half};
      end else if (psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_STATUS)) begin
         regs.rdata = status_word;
      end else if (psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_STICKY)) begin
         regs.rdata = {29'h0000_0000, s_q.sticky};
      end
   end

   // ==========================================
   // Next state
   // ==========================================
   logic [psfi_pkg::STK_W-1:0] stk_set;
   logic [psfi_pkg::STK_W-1:0] stk_clr;
   logic wr_ctrl;
   logic wr_flash;
   logic wr_sticky;

   // Register write decode.
   assign wr_ctrl = regs.wr_stb && psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_CTRL);
   assign wr_flash = regs.wr_stb && psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_FLASH);
   assign wr_sticky = regs.wr_stb && psfi_pkg::psfi_hit(regs.idx, psfi_pkg::OFF_STICKY);

   // Sticky events; write one to clear, a new event in the same cycle wins.
   assign stk_set = {link_fault, perm_fault, supply_fail};
   assign stk_clr = wr_sticky ? regs.wdata[psfi_pkg::STK_W-1:0] : '0;

   // Prescaler, flash toggle, registers and output flops.
   always_comb begin
      s_d = s_q;
      // Millisecond tick from the system clock, then a half-period count. [RULE_13]
      if (s_q.pre_cnt == TICK_LAST) begin
         s_d.pre_cnt = '0;
         if (s_q.ms_cnt + HALF_ONE >= s_q.flash_half) begin
            s_d.ms_cnt = '0;
            s_d.flash = !s_q.flash;
         end else begin
            s_d.ms_cnt = s_q.ms_cnt + HALF_ONE;
         end
      end else begin
         s_d.pre_cnt = s_q.pre_cnt + 1'b1;
      end
      if (wr_ctrl) begin
         s_d.sup_en = regs.wdata[7:0];
      end
      if (wr_flash) begin
         s_d.flash_half = regs.wdata[psfi_pkg::HALF_W-1:0];
      end
      s_d.sticky = (s_q.sticky & ~stk_clr) | stk_set;
      // Relay opens on any fault, so a dead coil also reads as a fault. [RULE_01]
      s_d.relay = !any_fault;
      // Fault LED shares the relay's fault term. [RULE_08] [RULE_14]
      s_d.led_fault = any_fault;
      // Supply LEDs: present and not under threshold. [RULE_07]
      s_d.led_s1 = good1 && !low1;
      s_d.led_s2 = good2 && !low2;
      s_d.led_green = green_d;
      s_d.led_yellow = yellow_d;
   end

   // State register; supervision enables start cleared. [RULE_05]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.sup_en <= psfi_pkg::CTRL_RST;
         s_q.flash_half <= psfi_pkg::FLASH_HALF_MS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // Outputs
   // ==========================================
   assign fault_relay_energise = s_q.relay;
   assign supply_one_led = s_q.led_s1;
   assign supply_two_led = s_q.led_s2;
   assign fault_led = s_q.led_fault;
   assign port_activity_led_green = s_q.led_green;
   assign port_activity_led_yellow = s_q.led_yellow;
endmodule

// ===== testbench/psfi_checker.sv
// Purpose: Port-level assertions for the indicator top.
// Assumes: Level inputs reach the outputs three edges later.
// Notes: Bound to psfi_top below the module.
`timescale 1ns/1ns
module psfi_checker #(
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Monitors, links and switches
   input wire logic supply_one_good,
   input wire logic supply_two_good,
   input wire logic supply_one_low,
   input wire logic supply_two_low,
   input wire logic rail_3v3_fail,
   input wire logic [7:0] port_link,
   input wire logic [7:0] port_rx_active,
   input wire logic link_mask_port_one,
   input wire logic link_mask_port_two,
   input wire logic link_mask_port_three,
   input wire logic link_mask_port_four,
   input wire logic link_mask_port_five,
   input wire logic link_mask_port_six,
   input wire logic link_mask_port_seven,
   input wire logic link_mask_port_eight,
   // Relay and indicators
   input wire logic fault_relay_energise,
   input wire logic supply_one_led,
   input wire logic supply_two_led,
   input wire logic fault_led,
   input wire logic [7:0] port_activity_led_green,
   input wire logic [7:0] port_activity_led_yellow
);
   // ==========================================
   // Helpers
   // ==========================================
   logic [7:0] m;
   logic sfail;
   logic [2:0] up_q;

   // Gather switches and supply faults.
   assign m = {link_mask_port_eight, link_mask_port_seven, link_mask_port_six, link_mask_port_five,
               link_mask_port_four, link_mask_port_three, link_mask_port_two, link_mask_port_one};
   assign sfail = ~supply_one_good | ~supply_two_good | supply_one_low | supply_two_low | rail_3v3_fail;

   // Counts edges since reset so that history never reaches into reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   end

   // ==========================================
   // Assertions
   // ==========================================
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_supply_opens: assert property ((up_q > 3'h4 && $past(sfail, 3)) |-> !fault_relay_energise)
      else $error("relay closed during supply fault");
   a_healthy_closed: assert property ((up_q > 3'h4 && !$past(sfail, 3)
      && $past((m & ~port_link) == 8'h00, 3)) |-> fault_relay_energise) else $error("relay open when healthy");
   a_rail_opens: assert property ((up_q > 3'h1 && $rose(rail_3v3_fail)) |-> ##3 !fault_relay_energise)
      else $error("rail fault missed");
   a_fault_led_relay: assert property (up_q > 3'h4 |-> fault_led != fault_relay_energise)
      else $error("fault led disagrees with relay");
   a_supply_led_one: assert property (up_q > 3'h4 |-> supply_one_led == $past(supply_one_good & ~supply_one_low, 3))
      else $error("supply one led wrong");
   a_supply_led_two: assert property (up_q > 3'h4 |-> supply_two_led == $past(supply_two_good & ~supply_two_low, 3))
      else $error("supply two led wrong");
   a_green_steady: assert property (up_q > 3'h4
      |-> port_activity_led_green == $past(port_link & m & ~port_rx_active, 3)) else $error("green led wrong");
   a_yellow_cause: assert property (up_q > 3'h4
      |-> (port_activity_led_yellow & ~$past(port_link & m & port_rx_active, 3)) == 8'h00) else $error("yellow lit");
   a_led_exclusive: assert property ((port_activity_led_green & port_activity_led_yellow) == 8'h00)
      else $error("green and yellow together");
endmodule

bind psfi_top psfi_checker #(.TICK_CYCLES(TICK_CYCLES)) u_psfi_checker (.*);

// ===== testbench/psfi_supervisor.sv
// Purpose: Remote supervisor watching the fault relay contact.
// Assumes: Contact high means closed.
// Notes: No contact current reads as alarm.
`timescale 1ns/1ns
module psfi_supervisor (
   // Relay contact, high while closed
   input wire logic contact_closed,
   // Alarm raised at the remote station
   output logic alarm
);
   // An open contact is a fault, so a dead unit alarms as well.
   assign alarm = ~contact_closed;
endmodule

// ===== testbench/port_status_fault_indicator_tb_top.sv
// Purpose: Self-checking bench for the indicator top.
// Assumes: Short flash tick of four cycles.
// Notes: Inputs change by non-blocking assignment after rising edges.
`timescale 1ns/1ns
module port_status_fault_indicator_tb_top;
   localparam int TICKS = 4;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [4:0] flt;
   logic [7:0] link, rx, mask, grn, yel;
   logic relay, led1, led2, fled, alarm;
   int n_errors, num_checks, cyc, hi;

   // ==========================================
   // Design and partner
   // ==========================================
   assign hready = hreadyout;
   psfi_top #(.TICK_CYCLES(TICKS)) u_psfi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .supply_one_good(~flt[0]), .supply_two_good(~flt[1]),
      .supply_one_low(flt[2]), .supply_two_low(flt[3]), .rail_3v3_fail(flt[4]), .port_link(link),
      .port_rx_active(rx), .link_mask_port_one(mask[0]), .link_mask_port_two(mask[1]),
      .link_mask_port_three(mask[2]), .link_mask_port_four(mask[3]), .link_mask_port_five(mask[4]),
      .link_mask_port_six(mask[5]), .link_mask_port_seven(mask[6]), .link_mask_port_eight(mask[7]),
      .fault_relay_energise(relay), .supply_one_led(led1), .supply_two_led(led2), .fault_led(fled),
      .port_activity_led_green(grn), .port_activity_led_yellow(yel));
   psfi_supervisor u_psfi_supervisor (.contact_closed(relay), .alarm(alarm));

   // Free-running clock.
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ==========================================
   // Shared tasks
   // ==========================================
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // One single-word transfer; the address phase holds until hready is seen high.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= psfi_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // Applies levels, then waits past the three-edge input latency.
   task automatic set_in(input logic [4:0] f, input logic [7:0] l, input logic [7:0] r, input logic [7:0] m);
      @(posedge hclk);
      flt <= f;
      link <= l;
      rx <= r;
      mask <= m;
      repeat (5) @(posedge hclk);
   endtask

   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_defaults();
      set_in(5'h00, 8'h00, 8'h00, 8'hff);
      chk("relay", relay, 1);
      chk("alarm", alarm, 0);
      xfer(1'b0, 32'(psfi_pkg::OFF_CTRL), 0);
      chk("ctrl", rd, 32'(psfi_pkg::CTRL_RST));
      xfer(1'b0, 32'(psfi_pkg::OFF_FLASH), 0);
      chk("flash", rd, 32'(psfi_pkg::FLASH_HALF_MS_RST));
      xfer(1'b0, 32'h0000_0040, 0);
      chk("unmapped", rd, 0);
      chk("hresp", hresp, 0);
   endtask

   task automatic t_supply();
      for (int k = 0; k < 5; k++) begin
         set_in(5'h01 << k, 8'hff, 8'h00, 8'hff);
         chk("relay", relay, 0);
         chk("alarm", alarm, 1);
         chk("fault led", fled, 1);
         chk("led1", led1, (k != 0 && k != 2));
         chk("led2", led2, (k != 1 && k != 3));
      end
      set_in(5'h00, 8'hff, 8'h00, 8'hff);
      chk("relay", relay, 1);
      chk("fault led", fled, 0);
      // Supply and permanent faults were seen above, so both sticky bits are set until cleared.
      xfer(1'b0, 32'(psfi_pkg::OFF_STICKY), 0);
      chk("sticky", rd, 32'h0000_0003);
      xfer(1'b1, 32'(psfi_pkg::OFF_STICKY), 32'h0000_0007);
      xfer(1'b0, 32'(psfi_pkg::OFF_STICKY), 0);
      chk("sticky cleared", rd, 0);
   endtask

   task automatic t_link();
      xfer(1'b1, 32'(psfi_pkg::OFF_CTRL), 32'h0000_0008);
      set_in(5'h00, 8'hf7, 8'h00, 8'hff);
      chk("relay", relay, 0);
      set_in(5'h00, 8'hfb, 8'h00, 8'hff);
      chk("relay", relay, 1);
      set_in(5'h00, 8'hf7, 8'h00, 8'hf7);
      chk("relay", relay, 1);
      xfer(1'b1, 32'(psfi_pkg::OFF_CTRL), 0);
   endtask

   task automatic t_port();
      for (int p = 0; p < 8; p++) begin
         for (int c = 0; c < 8; c++) begin
            set_in(5'h00, 8'(c & 1) << p, 8'((c >> 2) & 1) << p, 8'((c >> 1) & 1) << p);
            chk("green", grn, (c == 3) ? (32'h1 << p) : 0);
            if (c != 7) chk("yellow", yel, 0);
         end
      end
   endtask

   task automatic t_flash();
      xfer(1'b1, 32'(psfi_pkg::OFF_FLASH), 32'h0000_0001);
      set_in(5'h00, 8'h01, 8'h01, 8'h01);
      hi = 0;
      repeat (40) begin
         @(posedge hclk);
         hi += int'(yel[0] === 1'b1);
      end
      chk("yellow blinks", (hi != 0 && hi != 40), 1);
      chk("green", grn, 0);
   endtask

   // ==========================================
   // Main sequence and timeout
   // ==========================================
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      flt = 5'h00;
      link = 8'h00;
      rx = 8'h00;
      mask = 8'hff;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_defaults();
      t_supply();
      t_link();
      t_port();
      t_flash();
      test_done();
   end

   // Cuts a hang short.
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
endmodule
